// *** common/burst_sram_consts.vh ***
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
// burst order select levels
`define ORDER_LINEAR 1'b0
`define ORDER_INTERLEAVED 1'b1
// sleep entry and exit, in clock cycles
`define SLEEP_ENTER_CYCLES 2'd2
`define SLEEP_EXIT_CYCLES 2'd2
// beat counter reset value
`define BEAT_RESET 2'h0
// read capture fifo shape
`define CAP_FIFO_DEPTH 32
`define CAP_FIFO_AW 5
`endif

// *** rtl/pipelined_burst_sram_port.v ***
// Function
// R1 - read starts: qualified edge, all selects active, write high, load low
// R2 - read data driven at the edge after the read command edge
// R3 - controller holds output enable low to see read data
// R4 - new command accepted on the edge right after a read
// R5 - deselect pipelined: outputs float after the following edge
// R6 - burst counter gives up to four beats from one address
// R7 - controller drives step_or_load low to load a new address
// R8 - burst order low selects linear, high selects interleaved
// R9 - bursts change only the two low address bits, wrapping in four
// R10 - step_or_load high advances counter regardless of selects or write
// R11 - access type captured at burst start, kept for all beats
// R12 - write starts: qualified edge, all selects active, write low
// R13 - edge after write releases data bus whatever output enable is
// R14 - write data latched on second edge after the command
// R15 - only byte lanes with low select are written
// R16 - controller avoids driving bus while memory outputs are active
// R17 - in a write burst step_or_load high ignores selects, advances
// R18 - controller drives byte selects in every write burst beat
// R19 - sleep request keeps data; entry and exit take two cycles
// R20 - accesses pending at sleep entry are dropped
// R21 - controller deselects before sleep and waits after leaving it
// R22 - linear order counts low bits upward modulo four
// R23 - clock_qualify_n high: edge ignored, all state held; pin sync flops, sleep states and fifo reads still advance
// R24 - after reset deselected, data outputs floating
// R25 - interleaved order: low bits are loaded bits xor beat count
// R26 - write command and address ride a two-stage pipeline
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_consts.vh"
module pipelined_burst_sram_port #(
  parameter AW = 10,
  parameter LANES = 4,
  parameter FIFO_DEPTH = `CAP_FIFO_DEPTH,
  parameter FIFO_AW = `CAP_FIFO_AW
) (
  input wire clock,
  input wire rst_n,
  input wire clock_qualify_n,
  input wire chip_select_1_n,
  input wire chip_select_2,
  input wire chip_select_3_n,
  input wire step_or_load,
  input wire write_sel_n,
  input wire [LANES-1:0] byte_lane_select_n,
  input wire burst_order,
  input wire output_drive_en_n,
  input wire sleep_request,
  input wire [AW-1:0] address,
  input wire [8*LANES-1:0] data_bus_in,
  input wire [LANES-1:0] parity_bus_in,
  output reg [8*LANES-1:0] data_bus_out,
  output reg [LANES-1:0] parity_bus_out,
  output wire data_bus_oe,
  output wire in_sleep,
  output wire cap_valid,
  input wire cap_ready,
  output wire [9*LANES-1:0] cap_data
);
  localparam LW = 9 * LANES;
  localparam DEPTH = 1 << AW;
  // one-hot sleep states
  localparam S_RUN = 4'b0001;
  localparam S_ENTER = 4'b0010;
  localparam S_SLEEP = 4'b0100;
  localparam S_EXIT = 4'b1000;

  // next burst offset for the chosen order
  function [1:0] burst_bits;
    input order;
    input [1:0] base;
    input [1:0] beat;
    begin
      if (order == `ORDER_INTERLEAVED) begin
        burst_bits = base ^ beat; // R25
      end else begin
        burst_bits = base + beat; // R22
      end
    end
  endfunction

  // one lane of a core word: parity above its byte
  function [8:0] pick_lane;
    input [LW-1:0] word;
    input integer idx;
    begin
      pick_lane = word[9*idx +: 9];
    end
  endfunction

  // core array, byte and parity per lane
  reg [LW-1:0] core [0:DEPTH-1];

  // synchronised pins from outside
  reg sleep_s1_q;
  reg sleep_s2_q;
  reg ord_s1_q;
  reg ord_s2_q;
  reg oe_n_s1_q;
  reg oe_n_s2_q;

  reg [3:0] sleep_st_q;
  reg [3:0] sleep_st_d;
  reg [1:0] sleep_cnt_q;
  reg [1:0] sleep_cnt_d;

  // burst state
  reg [AW-1:0] base_q;
  reg [1:0] beat_q;
  reg wr_burst_q;
  reg active_q;
  reg order_q;

  // stage one: access decided this edge
  reg s1_rd_q;
  reg s1_wr_q;
  reg [AW-1:0] s1_addr_q;
  reg [LANES-1:0] s1_be_n_q;
  // stage two: write waiting for its data
  reg s2_wr_q;
  reg [AW-1:0] s2_addr_q;
  reg [LANES-1:0] s2_be_n_q;
  reg drive_q;

  wire qual;
  wire all_sel;
  wire load;
  wire advance;
  wire awake;
  wire [AW-1:0] step_addr;
  wire [1:0] next_beat;
  wire [LW-1:0] wr_word;
  wire [LW-1:0] old_word;
  wire fifo_in_ready;
  wire [LW-1:0] rd_word;
  wire cap_push;
  integer i;

  // read word fetched once for the output register and the fifo
  assign rd_word = core[s1_addr_q];
  assign cap_push = qual & s1_rd_q;

  assign awake = sleep_st_q[0];
  assign in_sleep = ~awake;
  // a stalled capture fifo stalls the port like clock_qualify_n
  assign qual = ~clock_qualify_n & awake & fifo_in_ready; // R23
  assign all_sel = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
  assign load = qual & ~step_or_load;
  assign advance = qual & step_or_load & active_q; // R10 R17
  assign next_beat = beat_q + 2'h1;
  // only the two low bits move, wrapping inside four words
  assign step_addr = {base_q[AW-1:2],
    burst_bits(order_q, base_q[1:0], next_beat)}; // R9 R6

  // async pins pass two flops before use
  always @(posedge clock) begin
    if (!rst_n) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      ord_s1_q <= 1'b0;
      ord_s2_q <= 1'b0;
      oe_n_s1_q <= 1'b1;
      oe_n_s2_q <= 1'b1;
    end else begin
      sleep_s1_q <= sleep_request;
      sleep_s2_q <= sleep_s1_q;
      ord_s1_q <= burst_order;
      ord_s2_q <= ord_s1_q;
      oe_n_s1_q <= output_drive_en_n;
      oe_n_s2_q <= oe_n_s1_q;
    end
  end

  // sleep sequencing, two cycles each way
  always @* begin
    sleep_st_d = sleep_st_q;
    sleep_cnt_d = sleep_cnt_q;
    case (sleep_st_q)
      S_RUN: begin
        if (sleep_s2_q) begin
          sleep_st_d = S_ENTER;
          sleep_cnt_d = `SLEEP_ENTER_CYCLES - 2'd1;
        end
      end
      S_ENTER: begin
        if (sleep_cnt_q == 2'd1) begin
          sleep_st_d = S_SLEEP; // R19
        end else begin
          sleep_cnt_d = sleep_cnt_q - 2'd1;
        end
      end
      S_SLEEP: begin
        if (!sleep_s2_q) begin
          sleep_st_d = S_EXIT;
          sleep_cnt_d = `SLEEP_EXIT_CYCLES - 2'd1;
        end
      end
      S_EXIT: begin
        if (sleep_cnt_q == 2'd1) begin
          sleep_st_d = S_RUN; // R19
        end else begin
          sleep_cnt_d = sleep_cnt_q - 2'd1;
        end
      end
      default: begin
        sleep_st_d = S_RUN;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      sleep_st_q <= S_RUN;
      sleep_cnt_q <= 2'd0;
    end else begin
      sleep_st_q <= sleep_st_d;
      sleep_cnt_q <= sleep_cnt_d;
    end
  end

  // command decode and burst counter
  always @(posedge clock) begin
    if (!rst_n || !awake) begin
      // reset or sleep: deselected, pending work dropped
      active_q <= 1'b0; // R24 R20
      base_q <= {AW{1'b0}};
      beat_q <= `BEAT_RESET;
      wr_burst_q <= 1'b0;
      order_q <= `ORDER_LINEAR;
      s1_rd_q <= 1'b0;
      s1_wr_q <= 1'b0;
      s1_addr_q <= {AW{1'b0}};
      s1_be_n_q <= {LANES{1'b1}};
    end else if (load) begin
      // new command every edge, no gap after a read
      base_q <= address; // R1 R12 R4 R7
      beat_q <= `BEAT_RESET;
      order_q <= ord_s2_q; // R8
      active_q <= all_sel;
      wr_burst_q <= ~write_sel_n; // R11
      s1_rd_q <= all_sel & write_sel_n; // R1
      s1_wr_q <= all_sel & ~write_sel_n; // R12
      s1_addr_q <= address;
      s1_be_n_q <= byte_lane_select_n;
    end else if (advance) begin
      // selects and write select ignored here
      beat_q <= next_beat; // R10 R17
      s1_rd_q <= ~wr_burst_q; // R11
      s1_wr_q <= wr_burst_q; // R11
      s1_addr_q <= step_addr;
      s1_be_n_q <= byte_lane_select_n;
    end else if (qual) begin
      // continue deselect
      s1_rd_q <= 1'b0; // R5
      s1_wr_q <= 1'b0;
    end else begin
      // edge not qualified: burst state held R23
    end
  end

  // byte lane merge, unselected lanes keep old bytes
  assign old_word = core[s2_addr_q];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      assign wr_word[9*g +: 9] = s2_be_n_q[g] ? pick_lane(old_word, g) :
        {parity_bus_in[g], data_bus_in[8*g +: 8]}; // R15
    end
  endgenerate

  // second stage: write data lands two edges after the command
  always @(posedge clock) begin
    if (!rst_n || !awake) begin
      s2_wr_q <= 1'b0; // R20
      s2_addr_q <= {AW{1'b0}};
      s2_be_n_q <= {LANES{1'b1}};
    end else if (qual) begin
      s2_wr_q <= s1_wr_q; // R26
      s2_addr_q <= s1_addr_q;
      s2_be_n_q <= s1_be_n_q;
    end else begin
      // stall: pending write keeps waiting for its data R23
    end
  end

  always @(posedge clock) begin
    if (rst_n && qual && s2_wr_q) begin
      core[s2_addr_q] <= wr_word; // R14 R15
    end
  end

  // read output register, drives after the command edge
  always @(posedge clock) begin
    if (!rst_n || !awake) begin
      drive_q <= 1'b0; // R24
      data_bus_out <= {(8*LANES){1'b0}};
      parity_bus_out <= {LANES{1'b0}};
    end else if (qual) begin
      // write data phase or deselect leaves the bus released
      drive_q <= s1_rd_q; // R2 R5 R13
      if (s1_rd_q) begin
        for (i = 0; i < LANES; i = i + 1) begin
          data_bus_out[8*i +: 8] <= rd_word[9*i +: 8];
          parity_bus_out[i] <= rd_word[9*i + 8];
        end
      end
    end else begin
      // stall: read data keeps standing on the bus R23
    end
  end

  // output enable pin gates the drivers; synced so it lags two cycles
  assign data_bus_oe = drive_q & ~oe_n_s2_q; // R3 R16

  // every read beat also copied to the capture fifo
  word_fifo #(
    .WIDTH(LW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_cap (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(cap_push),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(cap_valid),
    .out_ready(cap_ready),
    .out_data(cap_data)
  );
  // R18 R21: byte selects sampled each beat; sleep deselects anyway
endmodule // pipelined_burst_sram_port
`default_nettype wire

// *** rtl/word_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // honest full and empty from the occupancy count
  // full is the count's top bit, since depth is a power of two
  assign in_ready = ~cnt_q[AW];
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset, only pointers and count do
  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointer and count update
  always @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

// *** sim/pipelined_burst_sram_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_port_checker #(
  parameter LANES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic step_or_load,
  input wire logic write_sel_n,
  input wire logic output_drive_en_n,
  input wire logic sleep_request,
  input wire logic [8*LANES-1:0] data_bus_out,
  input wire logic data_bus_oe,
  input wire logic in_sleep,
  input wire logic cap_valid
);
  logic [1:0] oe_hist_q;
  // enable history, covers the two-flop sync lag
  always @(posedge clock) oe_hist_q <= {oe_hist_q[0], output_drive_en_n};
  // empty capture fifo means the edge cannot stall
  wire go = !clock_qualify_n && !in_sleep && !cap_valid;
  wire sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  wire ld = go && sel && !step_or_load;
  wire rd = ld && write_sel_n && !output_drive_en_n && oe_hist_q == 2'h0;
  wire nx = !clock_qualify_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_read_drive;
    rd ##1 nx |=> data_bus_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven");
  property p_read_burst;
    rd ##1 (nx && step_or_load) ##1 nx |=> data_bus_oe;
  endproperty
  a_read_burst: assert property (p_read_burst)
    else $error("burst beat not driven");
  property p_write_float;
    ld && !write_sel_n ##1 nx |=> !data_bus_oe;
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("bus driven after write");
  property p_deselect;
    go && !sel && !step_or_load ##1 nx |=> !data_bus_oe;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("bus driven after deselect");
  property p_stall;
    clock_qualify_n && !sleep_request && !in_sleep |=> $stable(data_bus_out);
  endproperty
  a_stall: assert property (p_stall)
    else $error("output moved on ignored edge");
  property p_sleep_in;
    sleep_request [*8] |-> in_sleep;
  endproperty
  a_sleep_in: assert property (p_sleep_in)
    else $error("sleep not entered");
  property p_sleep_out;
    !sleep_request [*8] |-> !in_sleep;
  endproperty
  a_sleep_out: assert property (p_sleep_out)
    else $error("sleep not left");
  property p_sleep_quiet;
    in_sleep |-> !data_bus_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("bus driven asleep");
endmodule // sram_port_checker
bind pipelined_burst_sram_port sram_port_checker #(.LANES(LANES))
  u_sram_port_checker (.clock, .rst_n, .clock_qualify_n, .chip_select_1_n,
  .chip_select_2, .chip_select_3_n, .step_or_load, .write_sel_n,
  .output_drive_en_n, .sleep_request, .data_bus_out, .data_bus_oe,
  .in_sleep, .cap_valid);
`default_nettype wire

// *** sim/pipelined_burst_sram_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cap_ready = 1'b1;
  logic clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n;
  logic step_or_load, write_sel_n, burst_order, output_drive_en_n;
  logic sleep_request, data_bus_oe, in_sleep, cap_valid;
  logic [3:0] byte_lane_select_n, parity_bus_out;
  logic [9:0] address;
  logic [31:0] data_bus_out;
  logic [35:0] wr_word, cap_data, mem [0:1023];
  int error_cnt = 0;
  int comparisons = 0;
  // shared bus: the port wins while it drives
  wire [31:0] data_bus_in = data_bus_oe ? data_bus_out : wr_word[31:0];
  wire [3:0] parity_bus_in = data_bus_oe ? parity_bus_out : wr_word[35:32];
  wire [35:0] q = {parity_bus_out, data_bus_out};
  always #5 clock = ~clock;
  sram_host u_sram_host (.clock, .clock_qualify_n, .chip_select_1_n,
    .chip_select_2, .chip_select_3_n, .step_or_load, .write_sel_n,
    .byte_lane_select_n, .burst_order, .output_drive_en_n, .sleep_request,
    .address, .wr_word);
  pipelined_burst_sram_port u_pipelined_burst_sram_port (.clock, .rst_n,
    .clock_qualify_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
    .step_or_load, .write_sel_n, .byte_lane_select_n, .burst_order,
    .output_drive_en_n, .sleep_request, .address, .data_bus_in,
    .parity_bus_in, .data_bus_out, .parity_bus_out, .data_bus_oe,
    .in_sleep, .cap_valid, .cap_ready, .cap_data);
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle;
    u_sram_host.beat(1'b1, 1'b0, 1'b0, 4'hf, 10'h000, 36'h0);
  endtask
  task automatic rd(input logic [9:0] a);
    u_sram_host.beat(1'b1, 1'b1, 1'b0, 4'hf, a, 36'h0);
  endtask
  task automatic t_burst;
    for (int i = 0; i < 4; i++) begin
      mem[{8'h3d, 2'(i + 1)}] = {4'(i + 5), 24'h5a5a5a, 8'(i)};
      u_sram_host.beat(i == 0, i == 0, 1'b1, 4'h0, 10'h0f5,
        mem[{8'h3d, 2'(i + 1)}]);
    end
    for (int i = 0; i < 5; i++) begin
      if (i < 4) rd({8'h3d, 2'(i + 1)});
      else idle();
      if (i > 0) chk(q, mem[{8'h3d, 2'(i)}]);
    end
    $display("t_burst done");
  endtask
  task automatic t_order(input logic ord, input logic [1:0] b);
    @(negedge clock);
    u_sram_host.burst_order = ord;
    repeat (3) idle();
    for (int i = 0; i < 5; i++) begin
      if (i < 4) u_sram_host.beat(i == 0, i == 0, 1'b0, 4'hf, {8'h3d, b},
        36'h0);
      else idle();
      if (i > 0) chk(q, mem[{8'h3d, ord ? b ^ 2'(i - 1)
        : b + 2'(i - 1)}]);
    end
    idle();
    chk({35'h0, data_bus_oe}, 36'h0);
    $display("t_order done");
  endtask
  task automatic t_lanes;
    logic [35:0] w;
    logic [35:0] e;
    w = 36'h9_a5a5_a5a5;
    e = mem[10'h0f5];
    // lanes 1 and 3 selected, the rest keep old bytes
    for (int g = 1; g < 4; g += 2) begin
      e[8*g +: 8] = w[8*g +: 8];
      e[32+g] = w[32+g];
    end
    rd(10'h0f6);
    u_sram_host.beat(1'b1, 1'b1, 1'b1, 4'h5, 10'h0f5, w);
    chk(q, mem[10'h0f6]);
    idle();
    chk({35'h0, data_bus_oe}, 36'h0);
    idle();
    rd(10'h0f5);
    idle();
    chk(q, e);
    mem[10'h0f5] = e;
    $display("t_lanes done");
  endtask
  task automatic t_stall;
    rd(10'h0f7);
    idle();
    u_sram_host.hold(3);
    chk({data_bus_oe, q[34:0]}, {1'b1, mem[10'h0f7][34:0]});
    idle();
    chk({35'h0, data_bus_oe}, 36'h0);
    $display("t_stall done");
  endtask
  task automatic t_fifo;
    int n;
    logic [35:0] p;
    // capture word packs each lane as parity over byte
    for (int g = 0; g < 4; g++)
      p[9*g +: 9] = {mem[10'h0f4][32+g], mem[10'h0f4][8*g +: 8]};
    @(negedge clock);
    cap_ready = 1'b0;
    repeat (34) rd(10'h0f4);
    chk({35'h0, cap_valid}, 36'h1);
    @(negedge clock);
    cap_ready = 1'b1;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      if (cap_valid === 1'b1) begin
        n++;
        chk(cap_data, p);
      end
      idle();
    end
    chk({35'h0, n >= 32 && n <= 34}, 36'h1);
    chk({35'h0, cap_valid}, 36'h0);
    $display("t_fifo done");
  endtask
  task automatic t_sleep;
    u_sram_host.snooze(1'b1);
    chk({34'h0, in_sleep, data_bus_oe}, 36'h2);
    u_sram_host.snooze(1'b0);
    chk({35'h0, in_sleep}, 36'h0);
    rd(10'h0f6);
    idle();
    chk(q, mem[10'h0f6]);
    $display("t_sleep done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    t_burst();
    t_order(1'b1, 2'h2);
    t_order(1'b0, 2'h3);
    t_lanes();
    t_stall();
    t_fifo();
    t_sleep();
    wrap_up();
  end
endmodule // pipelined_burst_sram_port_test
`default_nettype wire

// *** sim/sram_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_host (
  input wire logic clock,
  output logic clock_qualify_n,
  output logic chip_select_1_n,
  output logic chip_select_2,
  output logic chip_select_3_n,
  output logic step_or_load,
  output logic write_sel_n,
  output logic [3:0] byte_lane_select_n,
  output logic burst_order,
  output logic output_drive_en_n,
  output logic sleep_request,
  output logic [9:0] address,
  output logic [35:0] wr_word
);
  logic [35:0] pend0, pend1;
  logic wv0, wv1;
  // power-up: edges ignored, port enable low for good
  initial begin
    clock_qualify_n = 1'b1;
    burst_order = 1'b0;
    output_drive_en_n = 1'b0;
    sleep_request = 1'b0;
    wr_word = 36'h0;
    wv0 = 1'b0;
    wv1 = 1'b0;
  end
  // one command edge; write data trails its command by two edges
  task automatic beat(input logic ld, input logic sel, input logic wr,
      input logic [3:0] lanes_n, input logic [9:0] a, input logic [35:0] wd);
    @(negedge clock);
    clock_qualify_n = 1'b0;
    step_or_load = !ld;
    chip_select_1_n = !sel;
    chip_select_2 = sel;
    chip_select_3_n = !sel;
    write_sel_n = ld ? !wr : wr;
    address = a;
    byte_lane_select_n = lanes_n;
    if (wv1) wr_word = pend1;
    else wr_word = ~wr_word; // released bus never shows a stale value
    wv1 = wv0;
    pend1 = pend0;
    wv0 = wr && (sel || !ld);
    pend0 = wd;
    @(posedge clock);
    #1;
  endtask
  // stretch the cycle with unqualified edges
  task automatic hold(input int n);
    @(negedge clock);
    clock_qualify_n = 1'b1;
    repeat (n) @(posedge clock);
    #1;
  endtask
  // sleep change only while deselected, then stay deselected
  task automatic snooze(input logic on);
    beat(1'b1, 1'b0, 1'b0, 4'hf, 10'h000, 36'h0);
    @(negedge clock);
    sleep_request = on;
    repeat (10) beat(1'b1, 1'b0, 1'b0, 4'hf, 10'h000, 36'h0);
  endtask
endmodule // sram_host
`default_nettype wire
